// *** logic/tasg_pkg.sv ***
// Package for the tone and amplitude sound generator: register map, fields, types
package tasg_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_GENERATOR_CONTROL = 12'h198;
  localparam logic [ADDR_W-1:0] ADDR_TONE_FREQUENCY = 12'h19a;
  localparam logic [ADDR_W-1:0] ADDR_AMPLITUDE = 12'h19c;
  localparam logic [ADDR_W-1:0] ADDR_DECAY_STEP = 12'h19e;
  localparam logic [ADDR_W-1:0] ADDR_NOTE_CYCLE_COUNT = 12'h1a0;
  localparam logic [ADDR_W-1:0] ADDR_NOTE_STATUS = 12'h1a2;

  // generator_control fields
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_SEL_W = 3;
  localparam int CTRL_IRQ_EN_BIT = 4;

  // note_status fields (write one to clear the flag)
  localparam int STAT_NOTE_DONE_BIT = 0;
  localparam int STAT_TONE_BIT = 1;
  localparam int STAT_PULSE_BIT = 2;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Input clock select codes
  localparam logic [2:0] SEL_DIV1 = 3'h0;
  localparam logic [2:0] SEL_DIV2 = 3'h1;
  localparam logic [2:0] SEL_DIV4 = 3'h2;
  localparam logic [2:0] SEL_DIV8 = 3'h3;
  localparam logic [2:0] SEL_DIV16 = 3'h4;

  // Prescaler width covers the largest divide of sixteen
  localparam int PRESC_W = 4;
  // One amplitude pulse cycle is this many selected input clocks
  localparam int PULSE_STEPS = 256;
  localparam int PULSE_W = 8;
  localparam logic [PULSE_W-1:0] PULSE_LAST = 8'hff;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tasg_bus_req_t;

  typedef struct packed {
    logic enable;
    logic irq_en;
    logic [CTRL_SEL_W-1:0] input_clock_select;
  } tasg_ctrl_t;

endpackage

// *** logic/tasg_core.sv ***
// Tone and amplitude sound generator with register port and note-end request
//
// Operation
// - Output combines a 50% duty tone signal and an amplitude pulse-width signal.
// - Pulse cycle rate comes from the clock through the divider; duty follows amplitude.
// - Amplitude duty is held over a whole tone cycle; changes land between cycles.
// - Tone cycles are counted; reaching note_cycle_count raises the note-end request.
// - Each tone cycle lowers the amplitude by decay_step, down to a floor of zero.
// - Clock select 000..100 divides the input clock by 1, 2, 4, 8, 16.
// - One amplitude pulse cycle lasts exactly 256 selected input clocks.
// - Amplitude 0xff gives full duty; 0x00 gives the smallest duty.
// - Tone frequency is the pulse rate over twice the tone frequency value.
`timescale 1ns/1ps

module tasg_core #(
  parameter int PRESC_W_P = tasg_pkg::PRESC_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire tasg_pkg::tasg_bus_req_t bus_req,
  output logic [tasg_pkg::DATA_W-1:0] bus_rdata,
  output logic sound_out,
  output logic note_end_irq
);
  import tasg_pkg::*;

  // Subtract with a floor of zero so a long decay leaves the smallest duty, not a loud wrap
  function automatic logic [7:0] sat_sub(input logic [7:0] a, input logic [7:0] b);
    sat_sub = (a > b) ? 8'(a - b) : BYTE_RESET;
  endfunction

  // Divide ratio minus one for a select code; codes above 100 act as 100
  function automatic logic [PRESC_W_P-1:0] div_last(input logic [2:0] sel);
    case (sel)
      SEL_DIV1: div_last = PRESC_W_P'(0);
      SEL_DIV2: div_last = PRESC_W_P'(1);
      SEL_DIV4: div_last = PRESC_W_P'(3);
      SEL_DIV8: div_last = PRESC_W_P'(7);
      SEL_DIV16: div_last = PRESC_W_P'(15);
      default: div_last = PRESC_W_P'(15);
    endcase
  endfunction

  // Software-visible state
  logic [DATA_W-1:0] generator_control;
  logic [7:0] tone_frequency_value;
  logic [7:0] amplitude_value;
  logic [7:0] decay_step;
  logic [7:0] note_cycle_count;
  logic note_done;

  // Generator state
  logic [PRESC_W_P-1:0] presc_cnt;
  logic [PULSE_W-1:0] pulse_cnt;
  logic [7:0] half_cnt;
  logic [7:0] tone_cycles;
  logic [7:0] amp_active;
  logic tone;

  // Register port decode
  wire wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_GENERATOR_CONTROL);
  wire wr_freq = bus_req.wr && (bus_req.addr == ADDR_TONE_FREQUENCY);
  wire wr_ampl = bus_req.wr && (bus_req.addr == ADDR_AMPLITUDE);
  wire wr_decay = bus_req.wr && (bus_req.addr == ADDR_DECAY_STEP);
  wire wr_count = bus_req.wr && (bus_req.addr == ADDR_NOTE_CYCLE_COUNT);
  wire wr_stat = bus_req.wr && (bus_req.addr == ADDR_NOTE_STATUS);

  tasg_ctrl_t ctrl;
  assign ctrl.enable = generator_control[CTRL_ENABLE_BIT];
  assign ctrl.irq_en = generator_control[CTRL_IRQ_EN_BIT];
  assign ctrl.input_clock_select = generator_control[CTRL_SEL_LSB +: CTRL_SEL_W];

  // Prescaler tick: one enable pulse per selected input clock
  wire [PRESC_W_P-1:0] presc_last = div_last(ctrl.input_clock_select);
  wire tick = ctrl.enable && (presc_cnt >= presc_last);
  wire [PRESC_W_P-1:0] next_presc_cnt =
    (!ctrl.enable || tick) ? PRESC_W_P'(0) : PRESC_W_P'(presc_cnt + 1'b1);

  // Pulse cycle of 256 ticks; while enabled, its last tick is the only point where tone changes
  wire pulse_end = tick && (pulse_cnt == PULSE_LAST);
  wire [PULSE_W-1:0] next_pulse_cnt =
    !ctrl.enable ? '0 : (tick ? PULSE_W'(pulse_cnt + 1'b1) : pulse_cnt);

  // Tone half period is tone_frequency_value pulse cycles; value 0 acts as 256
  wire half_end = pulse_end && (half_cnt == 8'(tone_frequency_value - 1'b1));
  wire tone_cycle_end = half_end && tone;
  wire [7:0] next_half_cnt =
    (!ctrl.enable || half_end) ? BYTE_RESET : (pulse_end ? 8'(half_cnt + 1'b1) : half_cnt);
  wire next_tone = !ctrl.enable ? 1'b0 : (half_end ? !tone : tone);

  // Note length counter; the request marks the end of a note
  wire count_hit = tone_cycle_end && (8'(tone_cycles + 1'b1) == note_cycle_count);
  wire [7:0] next_tone_cycles =
    (!ctrl.enable || count_hit) ? BYTE_RESET :
    (tone_cycle_end ? 8'(tone_cycles + 1'b1) : tone_cycles);

  // Amplitude: a fresh write beats the decay taken in the same cycle
  wire [7:0] next_amplitude_value =
    wr_ampl ? bus_req.wdata[7:0] :
    (tone_cycle_end ? sat_sub(amplitude_value, decay_step) : amplitude_value);
  // Duty only changes at a tone cycle boundary, or while stopped
  wire [7:0] next_amp_active =
    (!ctrl.enable || tone_cycle_end) ? amplitude_value : amp_active;

  // High while the step count is at or below the amplitude: 0xff is always high while enabled
  wire amp_pulse = ctrl.enable && (pulse_cnt <= amp_active);
  wire next_sound_out = tone && amp_pulse;

  // Set wins over a clear in the same cycle
  wire next_note_done =
    count_hit ? 1'b1 : ((wr_stat && bus_req.wdata[STAT_NOTE_DONE_BIT]) ? 1'b0 : note_done);

  // Read mux; unmapped addresses read zero
  logic [DATA_W-1:0] next_rdata;
  always_comb begin
    next_rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_GENERATOR_CONTROL: next_rdata = generator_control;
        ADDR_TONE_FREQUENCY: next_rdata = {8'h00, tone_frequency_value};
        ADDR_AMPLITUDE: next_rdata = {8'h00, amplitude_value};
        ADDR_DECAY_STEP: next_rdata = {8'h00, decay_step};
        ADDR_NOTE_CYCLE_COUNT: next_rdata = {8'h00, note_cycle_count};
        ADDR_NOTE_STATUS: begin
          next_rdata[STAT_NOTE_DONE_BIT] = note_done;
          next_rdata[STAT_TONE_BIT] = tone;
          next_rdata[STAT_PULSE_BIT] = amp_pulse;
        end
        default: next_rdata = '0;
      endcase
    end
  end

  // Registers written by software
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      generator_control <= CTRL_RESET;
      tone_frequency_value <= BYTE_RESET;
      decay_step <= BYTE_RESET;
      note_cycle_count <= BYTE_RESET;
    end else begin
      if (wr_ctrl) generator_control <= bus_req.wdata;
      if (wr_freq) tone_frequency_value <= bus_req.wdata[7:0];
      if (wr_decay) decay_step <= bus_req.wdata[7:0];
      if (wr_count) note_cycle_count <= bus_req.wdata[7:0];
    end
  end

  // Generator datapath
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      presc_cnt <= '0;
      pulse_cnt <= '0;
      half_cnt <= BYTE_RESET;
      tone <= 1'b0;
      tone_cycles <= BYTE_RESET;
      amplitude_value <= BYTE_RESET;
      amp_active <= BYTE_RESET;
    end else begin
      presc_cnt <= next_presc_cnt;
      pulse_cnt <= next_pulse_cnt;
      half_cnt <= next_half_cnt;
      tone <= next_tone;
      tone_cycles <= next_tone_cycles;
      amplitude_value <= next_amplitude_value;
      amp_active <= next_amp_active;
    end
  end

  // Outputs, each straight from a flip-flop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      note_done <= 1'b0;
      note_end_irq <= 1'b0;
      sound_out <= 1'b0;
      bus_rdata <= '0;
    end else begin
      note_done <= next_note_done;
      note_end_irq <= next_note_done && ctrl.irq_en;
      sound_out <= next_sound_out;
      bus_rdata <= next_rdata;
    end
  end

endmodule

// *** test/tasg_core_asserts.sv ***
// Port checker for the sound generator
`timescale 1ns/1ps
module tasg_core_asserts
  import tasg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire tasg_pkg::tasg_bus_req_t bus_req,
  input wire logic [tasg_pkg::DATA_W-1:0] bus_rdata,
  input wire logic sound_out,
  input wire logic note_end_irq
);
  logic [15:0] ctl;
  logic [7:0] amp;
  logic [7:0] fq;
  logic dz;
  logic [1:0] longs;
  int hi, lo, hl, dv, fn;
  // Two long lows after the last write guarantee a tone cycle end under the new settings
  wire ok = longs == 2'h2 && dz && ctl[CTRL_ENABLE_BIT];
  assign dv = ctl[3:1] > 3'h4 ? 16 : 1 << ctl[3:1];
  assign fn = fq == 8'h00 ? 256 : int'(fq);
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctl <= '0;
      amp <= '0;
      fq <= '0;
      dz <= 1'b1;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_GENERATOR_CONTROL: ctl <= bus_req.wdata;
        ADDR_TONE_FREQUENCY: fq <= bus_req.wdata[7:0];
        ADDR_AMPLITUDE: amp <= bus_req.wdata[7:0];
        ADDR_DECAY_STEP: dz <= bus_req.wdata[7:0] == 8'h00;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!reset_n || bus_req.wr) begin
      longs <= '0;
    end else if (sound_out && lo >= 256 * dv && longs != 2'h2) begin
      longs <= longs + 2'h1;
    end
    hi <= sound_out ? hi + 1 : 0;
    lo <= (sound_out || !reset_n) ? 0 : lo + 1;
    if (!sound_out && hi != 0) begin
      hl <= hi;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sequence s_fall_ok; $fell(sound_out) && ok; endsequence
  property p_rd_idle; !bus_req.rd |=> bus_rdata == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_ctl; bus_req.rd && bus_req.addr == ADDR_GENERATOR_CONTROL |=> bus_rdata == ctl; endproperty
  a_rd_ctl: assert property (p_rd_ctl) else $error("control readback");
  property p_rd_fq; bus_req.rd && bus_req.addr == ADDR_TONE_FREQUENCY |=> bus_rdata == {8'h00, fq}; endproperty
  a_rd_fq: assert property (p_rd_fq) else $error("frequency readback");
  property p_off; !ctl[CTRL_ENABLE_BIT] [*3] |-> !sound_out; endproperty
  a_off: assert property (p_off) else $error("sound while stopped");
  property p_irq; !ctl[CTRL_IRQ_EN_BIT] [*2] |-> !note_end_irq; endproperty
  a_irq: assert property (p_irq) else $error("request while masked");
  property p_duty; s_fall_ok ##0 amp != 8'hff |-> hi == (int'(amp) + 1) * dv; endproperty
  a_duty: assert property (p_duty) else $error("pulse high length");
  property p_full; s_fall_ok ##0 amp == 8'hff |-> hi == fn * 256 * dv; endproperty
  a_full: assert property (p_full) else $error("full duty length");
  property p_half; $rose(sound_out) && ok && amp == 8'hff |-> lo == hl; endproperty
  a_half: assert property (p_half) else $error("tone not half duty");
endmodule
bind tasg_core tasg_core_asserts chk (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .sound_out(sound_out), .note_end_irq(note_end_irq));

// *** test/tasg_audio_sink.sv ***
// Audio path model: times the pulses seen on the sound pin
`timescale 1ns/1ps
module tasg_audio_sink (
  input wire logic clk_sys,
  input wire logic pin,
  output int period,
  output int high
);
  int t = 0;
  int h = 0;
  logic last = 1'b0;
  always @(posedge clk_sys) begin
    last <= pin;
    t <= (pin && !last) ? 1 : t + 1;
    h <= pin ? h + 1 : 0;
    if (pin && !last) period <= t;
    if (!pin && last) high <= h;
  end
endmodule

// *** test/testbench.sv ***
// Self-checking bench for the sound generator
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import tasg_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  tasg_bus_req_t bus_req = '0;
  logic [DATA_W-1:0] bus_rdata, d;
  logic sound_out, note_end_irq;
  logic [2:0] sel;
  logic [7:0] f, a;
  int period, high, n, dv, err_count = 0, checks = 0, seed = 32'h5294;
  tasg_core uut (.clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .sound_out(sound_out), .note_end_irq(note_end_irq));
  tasg_audio_sink sink (.clk_sys(clk_sys), .pin(sound_out), .period(period), .high(high));
  task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] wd);
    bus_req <= '{addr: ad, wdata: wd, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] ad);
    bus_req <= '{addr: ad, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1 d = bus_rdata;
    @(posedge clk_sys);
  endtask
  task automatic print_verdict();
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    // At most about 59.5k cycles of tests; the limit leaves room but stays well inside the run budget
    #640000;
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(ADDR_GENERATOR_CONTROL);
    `CHK(d, CTRL_RESET)
    rd(12'h1fe);
    `CHK(d, 16'h0000)
    // Note of two tone cycles with a decay that overshoots zero
    wr(ADDR_TONE_FREQUENCY, 16'h0001);
    wr(ADDR_AMPLITUDE, 16'h0040);
    wr(ADDR_DECAY_STEP, 16'h0030);
    wr(ADDR_NOTE_CYCLE_COUNT, 16'h0002);
    wr(ADDR_GENERATOR_CONTROL, 16'h0011);
    n = 0;
    while (note_end_irq !== 1'b1 && n < 2000) begin
      @(posedge clk_sys);
      #1 n++;
    end
    @(posedge clk_sys);
    `CHK(n > 600 && n < 1100, 1'b1)
    rd(ADDR_AMPLITUDE);
    `CHK(d, 16'h0000)
    wr(ADDR_NOTE_STATUS, 16'h0001);
    #1 `CHK(note_end_irq, 1'b0)
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      sel = 3'(4 - i);
      dv = 1 << sel;
      f = sel < 3'h3 ? 8'($unsigned($random(seed)) % 2 + 1) : 8'h01;
      a = i == 0 ? 8'h00 : (i < 3 ? 8'hff : 8'($random(seed)));
      wr(ADDR_GENERATOR_CONTROL, 16'h0000);
      wr(ADDR_DECAY_STEP, 16'h0000);
      wr(ADDR_TONE_FREQUENCY, {8'h00, f});
      wr(ADDR_AMPLITUDE, {8'h00, a});
      wr(ADDR_GENERATOR_CONTROL, {12'h000, sel, 1'b1});
      repeat (6 * 256 * int'(f) * dv) @(posedge clk_sys);
      `CHK(high, a == 8'hff ? 256 * int'(f) * dv : (int'(a) + 1) * dv)
      if (a == 8'hff) `CHK(period, 512 * int'(f) * dv)
      rd(ADDR_TONE_FREQUENCY);
      `CHK(d, {8'h00, f})
    end
    print_verdict();
  end
endmodule
